// ==== pcw_pkg.sv ====
// Constants, page enumeration and carrier types for the paged configuration window
`default_nettype none

package pcw_pkg;

   localparam logic [7:0] APP_ID_MAIN     = 8'h03;
   localparam logic [7:0] CID_MASK_FIRST  = 8'h17;
   localparam logic [7:0] CID_MASK_SECOND = 8'h18;
   localparam logic [7:0] CID_CALIB       = 8'h19;
   localparam logic [7:0] CID_HIST        = 8'h81;

   localparam logic [7:0] PAGE_BASE         = 8'h24;
   localparam logic [7:0] MASK_ENABLE_FIRST = 8'h24;
   localparam logic [7:0] MASK_ENABLE_LAST  = 8'h41;
   localparam logic [7:0] CHSEL_FIRST       = 8'h42;
   localparam logic [7:0] CHSEL_LAST        = 8'h8c;
   localparam logic [7:0] MASK_HSHIFT       = 8'h8d;
   localparam logic [7:0] MASK_VSHIFT       = 8'h8e;
   localparam logic [7:0] MASK_HEXTENT      = 8'h8f;
   localparam logic [7:0] MASK_VEXTENT      = 8'h90;

   localparam logic [7:0] CALIB_FIRST  = 8'h24;
   localparam logic [7:0] CALIB_STATUS = 8'hdc;
   localparam logic [7:0] CALIB_LAST   = 8'hdf;
   localparam logic [7:0] CALIB_OK     = 8'h00;

   localparam logic [7:0] HIST_INDEX      = 8'h24;
   localparam logic [7:0] HIST_PAYLOAD    = 8'h25;
   localparam logic [7:0] HIST_SLOT       = 8'h26;
   localparam logic [7:0] HIST_DATA_FIRST = 8'h27;
   localparam logic [7:0] HIST_DATA_LAST  = 8'ha6;
   localparam logic [7:0] HIST_PAYLOAD_SZ = 8'h80;

   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] READ_IDLE  = 8'h00;

   localparam int MASK_BYTES  = MASK_VEXTENT - MASK_ENABLE_FIRST + 1;
   localparam int CALIB_BYTES = CALIB_LAST - CALIB_FIRST + 1;
   localparam int HIST_BYTES  = HIST_DATA_LAST - HIST_DATA_FIRST + 1;
   localparam int MASK_IW     = $clog2(MASK_BYTES);
   localparam int CALIB_IW    = $clog2(CALIB_BYTES);
   localparam int HIST_IW     = $clog2(HIST_BYTES);

   typedef enum logic [2:0] {
      PAGE_NONE,
      PAGE_MASK_FIRST,
      PAGE_MASK_SECOND,
      PAGE_CALIB,
      PAGE_HIST
   } pcw_page_e;

   // Signed value in half units
   typedef logic signed [7:0] pcw_half_unit_fixed_point_t;

   typedef struct packed {
      pcw_half_unit_fixed_point_t hShift;
      pcw_half_unit_fixed_point_t vShift;
      logic [7:0]                 hExtent;
      logic [7:0]                 vExtent;
   } pcw_mask_geom_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wrData;
      logic       wrEn;
      logic       rdEn;
   } pcw_reg_req_s;

endpackage : pcw_pkg

`default_nettype wire

// ==== pcw_page_sel.sv ====
// Page decode from identifiers and register offset
`default_nettype none

module pcw_page_sel
   import pcw_pkg::*;
#(
   parameter bit HAS_SECOND_MASK = 1'b1
) (
   input  wire logic [7:0] appId,
   input  wire logic [7:0] configId,
   input  wire logic [7:0] addr,
   output pcw_page_e       page,
   output logic [7:0]      offset,
   output logic            inPage
);

   always_comb begin
      page = PAGE_NONE;
      if (appId == APP_ID_MAIN) begin
         unique case (configId)
            CID_MASK_FIRST:  page = PAGE_MASK_FIRST;
            CID_MASK_SECOND: page = HAS_SECOND_MASK ? PAGE_MASK_SECOND : PAGE_NONE;
            CID_CALIB:       page = PAGE_CALIB;
            CID_HIST:        page = PAGE_HIST;
            default:         page = PAGE_NONE;
         endcase
      end
   end

   always_comb begin
      offset = addr - PAGE_BASE;
      unique case (page)
         PAGE_MASK_FIRST, PAGE_MASK_SECOND:
            inPage = (addr >= MASK_ENABLE_FIRST) && (addr <= MASK_VEXTENT);
         PAGE_CALIB:
            inPage = (addr >= CALIB_FIRST) && (addr <= CALIB_LAST);
         PAGE_HIST:
            inPage = (addr >= HIST_INDEX) && (addr <= HIST_DATA_LAST);
         default:
            inPage = 1'b0;
      endcase
   end

endmodule : pcw_page_sel

`default_nettype wire

// ==== pcw_byte_bank.sv ====
// Flip-flop byte store with a host port and an internal fill port
`default_nettype none

module pcw_byte_bank
   import pcw_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int IW    = 4
) (
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire logic               ce,
   input  wire logic               hostWe,
   input  wire logic [IW-1:0]      hostIdx,
   input  wire logic [7:0]         hostData,
   input  wire logic               fillWe,
   input  wire logic [IW-1:0]      fillIdx,
   input  wire logic [7:0]         fillData,
   output logic [DEPTH*8-1:0]      image
);

   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_byte
         // Internal fill wins over a host write to the same byte
         always_ff @(posedge clk) begin
            if (!rst_b) begin
               image[gi*8 +: 8] <= BYTE_RESET;
            end else if (ce) begin
               if (fillWe && (fillIdx == IW'(gi))) begin
                  image[gi*8 +: 8] <= fillData;
               end else if (hostWe && (hostIdx == IW'(gi))) begin
                  image[gi*8 +: 8] <= hostData;
               end
            end
         end
      end
   endgenerate

endmodule : pcw_byte_bank

`default_nettype wire

// ==== pcw_config_window.sv ====
// Paged register window for mask, calibration and histogram pages
`default_nettype none

module pcw_config_window
   import pcw_pkg::*;
#(
   parameter bit HAS_SECOND_MASK = 1'b1
) (
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   input  wire logic                     ce,
   input  wire logic [7:0]               appId,
   input  wire logic [7:0]               configId,
   input  wire logic                     zoneMode8x8,
   input  wire pcw_reg_req_s             regReq,
   output logic [7:0]                    regRdData,
   output logic                          regRdValid,
   output logic                          maskWarn,
   input  wire logic                     calibCapture,
   input  wire logic [7:0]               calibStatusIn,
   input  wire logic                     histHeaderLoad,
   input  wire logic [7:0]               histPacketIn,
   input  wire logic                     histSlotIn,
   input  wire logic                     histFillWe,
   input  wire logic [HIST_IW-1:0]       histFillIdx,
   input  wire logic [7:0]               histFillData,
   output logic [MASK_BYTES*8-1:0]       maskImageFirst,
   output logic [MASK_BYTES*8-1:0]       maskImageSecond,
   output pcw_mask_geom_s                maskGeomFirst,
   output pcw_mask_geom_s                maskGeomSecond,
   output logic [CALIB_BYTES*8-1:0]      calibImage,
   output logic                          calibGood,
   output logic [7:0]                    histPacketIdx,
   output logic                          histSlot,
   output logic [HIST_BYTES*8-1:0]       histImage
);

   pcw_page_e            page;
   logic [7:0]           offset;
   logic                 inPage;
   logic                 hostWr;
   logic                 maskWr;
   logic                 maskWrAllowed;
   logic                 calibWr;
   logic                 histDataWr;
   logic                 histDataHit;
   logic [MASK_IW-1:0]   maskIdx;
   logic [CALIB_IW-1:0]  calibIdx;
   logic [HIST_IW-1:0]   histIdx;
   logic [7:0]           rdData_d;
   logic [7:0]           histPacket_q;
   logic                 histSlot_q;
   logic [7:0]           rdData_q;
   logic                 rdValid_q;
   logic                 maskWarn_q;

   localparam logic [CALIB_IW-1:0] CALIB_STATUS_IDX = CALIB_IW'(CALIB_STATUS - CALIB_FIRST);

   pcw_page_sel #(
      .HAS_SECOND_MASK (HAS_SECOND_MASK)
   ) u_page_sel (
      .appId    (appId),
      .configId (configId),
      .addr     (regReq.addr),
      .page     (page),
      .offset   (offset),
      .inPage   (inPage)
   );

   // Index into the selected page store
   assign maskIdx     = offset[MASK_IW-1:0];
   assign calibIdx    = offset[CALIB_IW-1:0];
   assign histIdx     = HIST_IW'(regReq.addr - HIST_DATA_FIRST);
   assign histDataHit = (regReq.addr >= HIST_DATA_FIRST) && (regReq.addr <= HIST_DATA_LAST);

   assign hostWr        = regReq.wrEn && inPage;
   assign maskWr        = hostWr && ((page == PAGE_MASK_FIRST) || (page == PAGE_MASK_SECOND));
   assign maskWrAllowed = maskWr && !zoneMode8x8;
   assign calibWr       = hostWr && (page == PAGE_CALIB);
   assign histDataWr    = hostWr && (page == PAGE_HIST) && histDataHit;

   // Enable mask, channel select and geometry bytes, all reset to zero
   pcw_byte_bank #(
      .DEPTH (MASK_BYTES),
      .IW    (MASK_IW)
   ) u_mask_first (
      .clk      (clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .hostWe   (maskWrAllowed && (page == PAGE_MASK_FIRST)),
      .hostIdx  (maskIdx),
      .hostData (regReq.wrData),
      .fillWe   (1'b0),
      .fillIdx  ('0),
      .fillData (BYTE_RESET),
      .image    (maskImageFirst)
   );

   pcw_byte_bank #(
      .DEPTH (MASK_BYTES),
      .IW    (MASK_IW)
   ) u_mask_second (
      .clk      (clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .hostWe   (maskWrAllowed && (page == PAGE_MASK_SECOND)),
      .hostIdx  (maskIdx),
      .hostData (regReq.wrData),
      .fillWe   (1'b0),
      .fillIdx  ('0),
      .fillData (BYTE_RESET),
      .image    (maskImageSecond)
   );

   // Calibration block; capture copies the main status byte
   pcw_byte_bank #(
      .DEPTH (CALIB_BYTES),
      .IW    (CALIB_IW)
   ) u_calib (
      .clk      (clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .hostWe   (calibWr),
      .hostIdx  (calibIdx),
      .hostData (regReq.wrData),
      .fillWe   (calibCapture),
      .fillIdx  (CALIB_STATUS_IDX),
      .fillData (calibStatusIn),
      .image    (calibImage)
   );

   // Histogram data bytes
   pcw_byte_bank #(
      .DEPTH (HIST_BYTES),
      .IW    (HIST_IW)
   ) u_hist (
      .clk      (clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .hostWe   (histDataWr),
      .hostIdx  (histIdx),
      .hostData (regReq.wrData),
      .fillWe   (histFillWe),
      .fillIdx  (histFillIdx),
      .fillData (histFillData),
      .image    (histImage)
   );

   // Geometry view of each mask page
   assign maskGeomFirst.hShift  = maskImageFirst[8*(MASK_HSHIFT - PAGE_BASE) +: 8];
   assign maskGeomFirst.vShift  = maskImageFirst[8*(MASK_VSHIFT - PAGE_BASE) +: 8];
   assign maskGeomFirst.hExtent = maskImageFirst[8*(MASK_HEXTENT - PAGE_BASE) +: 8];
   assign maskGeomFirst.vExtent = maskImageFirst[8*(MASK_VEXTENT - PAGE_BASE) +: 8];
   assign maskGeomSecond.hShift  = maskImageSecond[8*(MASK_HSHIFT - PAGE_BASE) +: 8];
   assign maskGeomSecond.vShift  = maskImageSecond[8*(MASK_VSHIFT - PAGE_BASE) +: 8];
   assign maskGeomSecond.hExtent = maskImageSecond[8*(MASK_HEXTENT - PAGE_BASE) +: 8];
   assign maskGeomSecond.vExtent = maskImageSecond[8*(MASK_VEXTENT - PAGE_BASE) +: 8];

   // Zero status means calibration succeeded
   assign calibGood = (calibImage[8*CALIB_STATUS_IDX +: 8] == CALIB_OK);

   // Histogram header: packet number and slot bit
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         histPacket_q <= BYTE_RESET;
         histSlot_q   <= 1'b0;
      end else if (ce) begin
         if (histHeaderLoad) begin
            histPacket_q <= histPacketIn;
            histSlot_q   <= histSlotIn;
         end else if (hostWr && (page == PAGE_HIST)) begin
            if (regReq.addr == HIST_INDEX) begin
               histPacket_q <= regReq.wrData;
            end
            if (regReq.addr == HIST_SLOT) begin
               histSlot_q <= regReq.wrData[0];
            end
         end
      end
   end

   assign histPacketIdx = histPacket_q;
   assign histSlot      = histSlot_q;

   // Read mux over the selected page
   always_comb begin
      rdData_d = READ_IDLE;
      if (inPage) begin
         unique case (page)
            PAGE_MASK_FIRST:  rdData_d = maskImageFirst[8*maskIdx +: 8];
            PAGE_MASK_SECOND: rdData_d = maskImageSecond[8*maskIdx +: 8];
            PAGE_CALIB:       rdData_d = calibImage[8*calibIdx +: 8];
            PAGE_HIST: begin
               if (regReq.addr == HIST_INDEX) begin
                  rdData_d = histPacket_q;
               end else if (regReq.addr == HIST_PAYLOAD) begin
                  rdData_d = HIST_PAYLOAD_SZ;
               end else if (regReq.addr == HIST_SLOT) begin
                  rdData_d = {7'h00, histSlot_q};
               end else begin
                  rdData_d = histImage[8*histIdx +: 8];
               end
            end
            default:          rdData_d = READ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdData_q  <= READ_IDLE;
         rdValid_q <= 1'b0;
      end else if (ce) begin
         rdValid_q <= regReq.rdEn;
         if (regReq.rdEn) begin
            rdData_q <= rdData_d;
         end
      end
   end

   assign regRdData  = rdData_q;
   assign regRdValid = rdValid_q;

   // Refused mask store in 8x8 mode
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         maskWarn_q <= 1'b0;
      end else if (ce) begin
         maskWarn_q <= maskWr && zoneMode8x8;
      end
   end

   assign maskWarn = maskWarn_q;

endmodule : pcw_config_window

`default_nettype wire

// ==== pcw_config_window_props.sv ====
// Concurrent checks of the paged configuration window
`default_nettype none
module pcw_config_window_props
   import pcw_pkg::*;
#(
   parameter bit HAS_SECOND_MASK = 1'b1
) (
   input wire logic                     clk,
   input wire logic                     rst_b,
   input wire logic                     ce,
   input wire logic [7:0]               appId,
   input wire logic [7:0]               configId,
   input wire logic                     zoneMode8x8,
   input wire pcw_reg_req_s             regReq,
   input wire logic [7:0]               regRdData,
   input wire logic                     regRdValid,
   input wire logic                     maskWarn,
   input wire logic                     calibCapture,
   input wire logic [7:0]               calibStatusIn,
   input wire logic                     histHeaderLoad,
   input wire logic [7:0]               histPacketIn,
   input wire logic                     histSlotIn,
   input wire logic                     histFillWe,
   input wire logic [HIST_IW-1:0]       histFillIdx,
   input wire logic [7:0]               histFillData,
   input wire logic [MASK_BYTES*8-1:0]  maskImageFirst,
   input wire logic [MASK_BYTES*8-1:0]  maskImageSecond,
   input wire pcw_mask_geom_s           maskGeomFirst,
   input wire logic [CALIB_BYTES*8-1:0] calibImage,
   input wire logic                     calibGood,
   input wire logic [7:0]               histPacketIdx,
   input wire logic                     histSlot,
   input wire logic [HIST_BYTES*8-1:0]  histImage
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int ST = int'(CALIB_STATUS - CALIB_FIRST) * 8;
   localparam int HS = int'(MASK_HSHIFT - MASK_ENABLE_FIRST) * 8;
   logic mainApp;
   logic maskAddr;
   assign mainApp  = appId == APP_ID_MAIN;
   assign maskAddr = regReq.addr >= MASK_ENABLE_FIRST && regReq.addr <= MASK_VEXTENT;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   sequence s_rdTake;
      ce && regReq.rdEn;
   endsequence
   sequence s_maskWr(cid);
      ce && regReq.wrEn && mainApp && configId == cid && maskAddr;
   endsequence
   property p_rdValid;
      s_rdTake |=> regRdValid;
   endproperty
   property p_payload;
      s_rdTake ##0 (mainApp && configId == CID_HIST && regReq.addr == HIST_PAYLOAD)
         |=> regRdData == HIST_PAYLOAD_SZ;
   endproperty
   property p_foreignApp;
      s_rdTake ##0 !mainApp |=> regRdData == READ_IDLE;
   endproperty
   property p_maskFirstWr;
      s_maskWr(CID_MASK_FIRST) ##0 !zoneMode8x8 |=> !maskWarn &&
         maskImageFirst[int'($past(regReq.addr) - 8'h24) * 8 +: 8] == $past(regReq.wrData);
   endproperty
   property p_maskSecondWr;
      s_maskWr(CID_MASK_SECOND) ##0 (HAS_SECOND_MASK && !zoneMode8x8) |=>
         $stable(maskImageFirst) &&
         maskImageSecond[int'($past(regReq.addr) - 8'h24) * 8 +: 8] == $past(regReq.wrData);
   endproperty
   property p_refuse8x8;
      s_maskWr(CID_MASK_FIRST) ##0 zoneMode8x8 |=> maskWarn && $stable(maskImageFirst);
   endproperty
   property p_calibGood;
      calibGood == (calibImage[ST +: 8] == CALIB_OK);
   endproperty
   property p_capture;
      ce && calibCapture |=> calibImage[ST +: 8] == $past(calibStatusIn);
   endproperty
   property p_header;
      ce && histHeaderLoad |=> histSlot == $past(histSlotIn) &&
         histPacketIdx == $past(histPacketIn);
   endproperty
   property p_fill;
      ce && histFillWe |=> histImage[int'($past(histFillIdx)) * 8 +: 8] == $past(histFillData);
   endproperty
   property p_geom;
      maskGeomFirst.hShift == maskImageFirst[HS +: 8];
   endproperty
   a_rdValid: assert property (p_rdValid) else $error("read not answered");
   a_payload: assert property (p_payload) else $error("payload size wrong");
   a_foreignApp: assert property (p_foreignApp) else $error("page seen off app");
   a_maskFirstWr: assert property (p_maskFirstWr) else $error("first mask write");
   a_maskSecondWr: assert property (p_maskSecondWr) else $error("second mask write");
   a_refuse8x8: assert property (p_refuse8x8) else $error("8x8 store not refused");
   a_calibGood: assert property (p_calibGood) else $error("calib flag wrong");
   a_capture: assert property (p_capture) else $error("status not copied");
   a_header: assert property (p_header) else $error("header not loaded");
   a_fill: assert property (p_fill) else $error("hist fill lost");
   a_geom: assert property (p_geom) else $error("shift field wrong");
endmodule : pcw_config_window_props

bind pcw_config_window pcw_config_window_props #(.HAS_SECOND_MASK(HAS_SECOND_MASK)) u_props (
   .clk, .rst_b, .ce, .appId, .configId, .zoneMode8x8, .regReq, .regRdData, .regRdValid,
   .maskWarn, .calibCapture, .calibStatusIn, .histHeaderLoad, .histPacketIn, .histSlotIn,
   .histFillWe, .histFillIdx, .histFillData, .maskImageFirst, .maskImageSecond,
   .maskGeomFirst, .calibImage, .calibGood, .histPacketIdx, .histSlot, .histImage);
`default_nettype wire

// ==== pcw_host_model.sv ====
// Host model issuing byte register requests
`default_nettype none
module pcw_host_model
   import pcw_pkg::*;
(
   input  wire logic       clk,
   output var pcw_reg_req_s regReq,
   input  wire logic [7:0] regRdData,
   input  wire logic       regRdValid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial regReq = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      regReq = '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
      @(negedge clk);
      regReq = '{addr: ~a, wrData: ~d, wrEn: 1'b0, rdEn: 1'b0};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      n = 0;
      @(negedge clk);
      regReq = '{addr: a, wrData: ~a, wrEn: 1'b0, rdEn: 1'b1};
      @(negedge clk);
      regReq = '{addr: ~a, wrData: a, wrEn: 1'b0, rdEn: 1'b0};
      while (regRdValid !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      d = (regRdValid === 1'b1) ? regRdData : 8'hxx;
   endtask : rd
endmodule : pcw_host_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the paged configuration window
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_fail++; \
   $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module tb_top
   import pcw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] app, cid, addr, wd, ex;
   } pcw_row_s;
   logic clk = 1'b0, rst_b = 1'b0, zoneMode8x8 = 1'b0, ce = 1'b1;
   logic [7:0] appId = 8'h03, configId = 8'h17, calibStatusIn = 8'h00;
   logic calibCapture = 1'b0, histHeaderLoad = 1'b0, histSlotIn = 1'b0, histFillWe = 1'b0;
   logic [7:0] histPacketIn = 8'h00, histFillData = 8'h00, rv, regRdData, histPacketIdx;
   logic [HIST_IW-1:0] histFillIdx = '0;
   pcw_reg_req_s regReq;
   logic regRdValid, maskWarn, calibGood, histSlot;
   logic [MASK_BYTES*8-1:0] maskImageFirst, maskImageSecond;
   logic [CALIB_BYTES*8-1:0] calibImage;
   logic [HIST_BYTES*8-1:0] histImage;
   pcw_mask_geom_s maskGeomFirst, maskGeomSecond;
   int n_fail = 0;
   int check_count = 0;
   pcw_row_s rows [18] = '{
      '{8'h03, 8'h17, 8'h24, 8'ha1, 8'ha1}, '{8'h03, 8'h17, 8'h41, 8'hb2, 8'hb2},
      '{8'h03, 8'h17, 8'h42, 8'hc3, 8'hc3}, '{8'h03, 8'h17, 8'h8c, 8'hd4, 8'hd4},
      '{8'h03, 8'h17, 8'h8d, 8'hfe, 8'hfe}, '{8'h03, 8'h18, 8'h24, 8'h5e, 8'h5e},
      '{8'h03, 8'h19, 8'h24, 8'h11, 8'h11}, '{8'h03, 8'h19, 8'hdf, 8'h22, 8'h22},
      '{8'h03, 8'h81, 8'h24, 8'h33, 8'h33}, '{8'h03, 8'h81, 8'h27, 8'h44, 8'h44},
      '{8'h03, 8'h81, 8'ha6, 8'h55, 8'h55}, '{8'h03, 8'h81, 8'h25, 8'h12, 8'h80},
      '{8'h03, 8'h81, 8'h26, 8'hff, 8'h01}, '{8'h04, 8'h17, 8'h30, 8'h66, 8'h00},
      '{8'h03, 8'h20, 8'h30, 8'h77, 8'h00}, '{8'h03, 8'h17, 8'h91, 8'h88, 8'h00},
      '{8'h03, 8'h19, 8'he0, 8'h99, 8'h00}, '{8'h03, 8'h18, 8'h8e, 8'hf6, 8'hf6}};
   pcw_config_window dut (
      .clk, .rst_b, .ce, .appId, .configId, .zoneMode8x8, .regReq, .regRdData,
      .regRdValid, .maskWarn, .calibCapture, .calibStatusIn, .histHeaderLoad, .histPacketIn,
      .histSlotIn, .histFillWe, .histFillIdx, .histFillData, .maskImageFirst,
      .maskImageSecond, .maskGeomFirst, .maskGeomSecond, .calibImage, .calibGood,
      .histPacketIdx, .histSlot, .histImage);
   pcw_host_model host (.clk, .regReq, .regRdData, .regRdValid);
   always #5 clk = ~clk;
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run
   task automatic access(input pcw_row_s r, input bit w);
      @(negedge clk);
      appId = r.app;
      configId = r.cid;
      if (w) host.wr(r.addr, r.wd);
      host.rd(r.addr, rv);
   endtask : access
   initial begin
      #200us;
      n_fail++;
      complete_run();
   end
   initial begin
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      foreach (rows[i]) begin
         access(rows[i], 1'b1);
         `CHK("row", rows[i].ex, rv)
      end
      `CHK("hShift", maskGeomFirst.hShift, 8'shfe)
      `CHK("vShift2", 8'hf6, maskGeomSecond.vShift)
      access('{8'h03, 8'h17, 8'h24, 8'h00, 8'h00}, 1'b0);
      `CHK("route", 8'ha1, rv)
      access('{8'h03, 8'h19, 8'h24, 8'h00, 8'h00}, 1'b0);
      `CHK("route", 8'h11, rv)
      @(negedge clk);
      rst_b = 1'b0;
      @(negedge clk);
      rst_b = 1'b1;
      `CHK("calibGood", 1'b1, calibGood)
      access('{8'h03, 8'h17, 8'h24, 8'h00, 8'h00}, 1'b0);
      `CHK("reset", 8'h00, rv)
      access('{8'h03, 8'h81, 8'h25, 8'h00, 8'h00}, 1'b0);
      `CHK("payload", 8'h80, rv)
      configId = 8'h17;
      zoneMode8x8 = 1'b1;
      host.wr(8'h30, 8'h5a);
      `CHK("maskWarn", 1'b1, maskWarn)
      access('{8'h03, 8'h17, 8'h30, 8'h00, 8'h00}, 1'b0);
      `CHK("refused", 8'h00, rv)
      zoneMode8x8 = 1'b0;
      @(negedge clk);
      calibStatusIn = 8'h3c;
      calibCapture = 1'b1;
      histHeaderLoad = 1'b1;
      histPacketIn = 8'h07;
      histSlotIn = 1'b1;
      histFillWe = 1'b1;
      histFillIdx = 7'h7f;
      histFillData = 8'hcd;
      @(negedge clk);
      calibCapture = 1'b0;
      histHeaderLoad = 1'b0;
      histFillWe = 1'b0;
      `CHK("calibGood", 1'b0, calibGood)
      `CHK("histSlot", 1'b1, histSlot)
      `CHK("histPacketIdx", 8'h07, histPacketIdx)
      access('{8'h03, 8'h19, 8'hdc, 8'h00, 8'h00}, 1'b0);
      `CHK("status", 8'h3c, rv)
      access('{8'h03, 8'h81, 8'h26, 8'h00, 8'h00}, 1'b0);
      `CHK("slot", 8'h01, rv)
      access('{8'h03, 8'h81, 8'ha6, 8'h00, 8'h00}, 1'b0);
      `CHK("fill", 8'hcd, rv)
      // Store while the clock enable is low must be lost
      configId = 8'h17;
      ce = 1'b0;
      host.wr(8'h24, 8'h77);
      ce = 1'b1;
      access('{8'h03, 8'h17, 8'h24, 8'h00, 8'h00}, 1'b0);
      `CHK("freeze", 8'h00, rv)
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
